// ### logic/out_step_if.sv
`timescale 1ns/1ns
interface out_step_if;
    logic [6:0] target;
    vol_ctrl_pkg::soft_mode_t mode;
    logic tick;
    logic [6:0] cur;
    logic mute;
    logic pending;
    modport ctrl (output target, output mode, output tick, input cur, input mute, input pending);
    modport stepper (input target, input mode, input tick, output cur, output mute, output pending);
endinterface

// ### logic/out_vol_stepper.sv
`timescale 1ns/1ns
`include "output_pop_consts.svh"
module out_vol_stepper (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    out_step_if.stepper s
);
    logic [6:0] cur_q;
    logic [6:0] cur_d;
    logic half_q;
    logic mute_q;
    logic pending_q;

    always_comb begin
        cur_d = cur_q;
        case (s.mode)
            vol_ctrl_pkg::STEP_FS: begin
                if (s.tick && cur_q < s.target) begin
                    cur_d = cur_q + 7'h01;
                end else if (s.tick && cur_q > s.target) begin
                    cur_d = cur_q - 7'h01;
                end
            end
            vol_ctrl_pkg::STEP_2FS: begin
                if (s.tick && half_q && cur_q < s.target) begin
                    cur_d = cur_q + 7'h01;
                end else if (s.tick && half_q && cur_q > s.target) begin
                    cur_d = cur_q - 7'h01;
                end
            end
            vol_ctrl_pkg::STEP_NOW: cur_d = s.target;
            default: cur_d = cur_q;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur_q <= `RST_OUT_VOL;
            half_q <= 1'b0;
            mute_q <= 1'b0;
            pending_q <= 1'b0;
        end else if (clk_en) begin
            cur_q <= cur_d;
            if (s.tick) begin
                half_q <= ~half_q;
            end
            mute_q <= (cur_d >= `OUT_MUTE_MIN);
            pending_q <= (cur_d != s.target);
        end
    end

    assign s.cur = cur_q;
    assign s.mute = mute_q;
    assign s.pending = pending_q;
endmodule

// ### logic/output_pop_and_dac_volume_ctrl.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "output_pop_consts.svh"
module output_pop_and_dac_volume_ctrl #(
    parameter int unsigned PON_1MS = `PON_1MS_US * `CLK_MHZ,
    parameter int unsigned PON_10MS = `PON_10MS_US * `CLK_MHZ,
    parameter int unsigned PON_50MS = `PON_50MS_US * `CLK_MHZ,
    parameter int unsigned PON_100MS = `PON_100MS_US * `CLK_MHZ,
    parameter int unsigned PON_200MS = `PON_200MS_US * `CLK_MHZ,
    parameter int unsigned PON_400MS = `PON_400MS_US * `CLK_MHZ,
    parameter int unsigned PON_800MS = `PON_800MS_US * `CLK_MHZ,
    parameter int unsigned PON_4S = `PON_4S_US * `CLK_MHZ,
    parameter int unsigned PON_8S = `PON_8S_US * `CLK_MHZ,
    parameter int unsigned RAMP_1MS = `RAMP_1MS_US * `CLK_MHZ,
    parameter int unsigned RAMP_2MS = `RAMP_2MS_US * `CLK_MHZ,
    parameter int unsigned RAMP_4MS = `RAMP_4MS_US * `CLK_MHZ
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic drv_power_req,
    input wire logic sample_tick,
    input wire logic [6:0] out_vol_target,
    output logic drv_on,
    output logic [2:0] ramp_level,
    output logic vcm_bandgap,
    output logic left_mute,
    output logic [6:0] left_atten,
    output logic right_mute,
    output logic [6:0] right_atten,
    output logic [6:0] out_vol,
    output logic out_mute,
    output logic out_vol_pending
);
    localparam logic [26:0] PON_10US_CYC = 27'(`PON_10US_US * `CLK_MHZ);
    localparam logic [26:0] PON_100US_CYC = 27'(`PON_100US_US * `CLK_MHZ);

    logic [7:0] pop_q;
    logic [7:0] ldac_q;
    logic [7:0] rdac_q;
    vol_ctrl_pkg::soft_mode_t soft_q;
    vol_ctrl_pkg::link_mode_t link_q;
    logic [7:0] rdata_q;
    logic vcm_q;
    logic left_mute_q;
    logic [6:0] left_atten_q;
    logic right_mute_q;
    logic [6:0] right_atten_q;
    vol_ctrl_pkg::pwr_state_t state_q;
    logic [26:0] cnt_q;
    logic [2:0] level_q;
    logic drv_on_q;
    logic [7:0] eff_left;
    logic [7:0] eff_right;

    out_step_if step_bus ();

    function automatic logic [26:0] pon_cycles(input logic [3:0] code);
        case (code)
            4'h0: pon_cycles = 27'h0000000;
            4'h1: pon_cycles = PON_10US_CYC;
            4'h2: pon_cycles = PON_100US_CYC;
            4'h3: pon_cycles = 27'(PON_1MS);
            4'h4: pon_cycles = 27'(PON_10MS);
            4'h5: pon_cycles = 27'(PON_50MS);
            4'h6: pon_cycles = 27'(PON_100MS);
            4'h7: pon_cycles = 27'(PON_200MS);
            4'h8: pon_cycles = 27'(PON_400MS);
            4'h9: pon_cycles = 27'(PON_800MS);
            4'ha: pon_cycles = 27'(PON_8S);
            4'hb: pon_cycles = 27'(PON_4S);
            default: pon_cycles = 27'h0000000;
        endcase
    endfunction

    function automatic logic [26:0] ramp_cycles(input logic [1:0] code);
        case (code)
            2'h0: ramp_cycles = 27'h0000000;
            2'h1: ramp_cycles = 27'(RAMP_1MS);
            2'h2: ramp_cycles = 27'(RAMP_2MS);
            default: ramp_cycles = 27'(RAMP_4MS);
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] where);
        hit = (a == where);
    endfunction

    // Register writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pop_q <= `RST_POP;
            ldac_q <= `RST_DAC;
            rdac_q <= `RST_DAC;
            soft_q <= vol_ctrl_pkg::STEP_FS;
            link_q <= vol_ctrl_pkg::LINK_NONE;
        end else if (clk_en && wr_stb) begin
            if (hit(addr, `ADDR_POP)) begin
                pop_q <= wdata;
            end
            if (hit(addr, `ADDR_LDAC)) begin
                ldac_q <= wdata;
            end
            if (hit(addr, `ADDR_RDAC)) begin
                rdac_q <= wdata;
            end
            if (hit(addr, `ADDR_SOFT_STEP)) begin
                soft_q <= vol_ctrl_pkg::soft_mode_t'(wdata[1:0]);
            end
            if (hit(addr, `ADDR_VOL_LINK)) begin
                link_q <= vol_ctrl_pkg::link_mode_t'(wdata[1:0]);
            end
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= 8'h00;
            if (rd_stb) begin
                if (hit(addr, `ADDR_POP)) begin
                    rdata_q <= pop_q;
                end
                if (hit(addr, `ADDR_LDAC)) begin
                    rdata_q <= ldac_q;
                end
                if (hit(addr, `ADDR_RDAC)) begin
                    rdata_q <= rdac_q;
                end
                if (hit(addr, `ADDR_SOFT_STEP)) begin
                    rdata_q <= {6'h00, soft_q};
                end
                if (hit(addr, `ADDR_VOL_LINK)) begin
                    rdata_q <= {6'h00, link_q};
                end
                if (hit(addr, `ADDR_STATUS)) begin
                    rdata_q <= {state_q, level_q, step_bus.mute, step_bus.pending, drv_on_q};
                end
            end
        end
    end

    // Channel volume linking
    always_comb begin
        eff_left = ldac_q;
        eff_right = rdac_q;
        case (link_q)
            vol_ctrl_pkg::LINK_L_FOLLOWS_R: eff_left = rdac_q;
            vol_ctrl_pkg::LINK_R_FOLLOWS_L: eff_right = ldac_q;
            default: begin
                eff_left = ldac_q;
                eff_right = rdac_q;
            end
        endcase
    end

    // Digital mute and half-dB attenuation codes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            left_mute_q <= 1'b1;
            left_atten_q <= 7'h00;
            right_mute_q <= 1'b1;
            right_atten_q <= 7'h00;
            vcm_q <= 1'b0;
        end else if (clk_en) begin
            left_mute_q <= eff_left[`DAC_MUTE_BIT];
            left_atten_q <= eff_left[`DAC_VOL_MSB:0];
            right_mute_q <= eff_right[`DAC_MUTE_BIT];
            right_atten_q <= eff_right[`DAC_VOL_MSB:0];
            vcm_q <= pop_q[`POP_VCM_BIT];
        end
    end

    // Driver power-on delay and stepped ramp
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= vol_ctrl_pkg::PWR_IDLE;
            cnt_q <= 27'h0000000;
            level_q <= 3'h0;
            drv_on_q <= 1'b0;
        end else if (clk_en) begin
            if (!drv_power_req) begin
                state_q <= vol_ctrl_pkg::PWR_IDLE;
                cnt_q <= 27'h0000000;
                level_q <= 3'h0;
                drv_on_q <= 1'b0;
            end else begin
                case (state_q)
                    vol_ctrl_pkg::PWR_IDLE: begin
                        state_q <= vol_ctrl_pkg::PWR_DELAY;
                        cnt_q <= pon_cycles(pop_q[`POP_DLY_MSB:`POP_DLY_LSB]);
                    end
                    vol_ctrl_pkg::PWR_DELAY: begin
                        if (cnt_q != 27'h0000000) begin
                            cnt_q <= cnt_q - 27'h0000001;
                        end else begin
                            state_q <= vol_ctrl_pkg::PWR_RAMP;
                            cnt_q <= ramp_cycles(pop_q[`POP_RAMP_MSB:`POP_RAMP_LSB]);
                        end
                    end
                    vol_ctrl_pkg::PWR_RAMP: begin
                        if (cnt_q != 27'h0000000) begin
                            cnt_q <= cnt_q - 27'h0000001;
                        end else begin
                            level_q <= level_q + 3'h1;
                            cnt_q <= ramp_cycles(pop_q[`POP_RAMP_MSB:`POP_RAMP_LSB]);
                            if (level_q == `RAMP_TOP - 3'h1) begin
                                state_q <= vol_ctrl_pkg::PWR_ON;
                                drv_on_q <= 1'b1;
                            end
                        end
                    end
                    vol_ctrl_pkg::PWR_ON: begin
                        drv_on_q <= 1'b1;
                    end
                    default: state_q <= vol_ctrl_pkg::PWR_IDLE;
                endcase
            end
        end
    end

    // Output-stage analog volume, one path
    assign step_bus.target = out_vol_target;
    assign step_bus.mode = soft_q;
    assign step_bus.tick = sample_tick;

    out_vol_stepper u_stepper (
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .s(step_bus.stepper)
    );

    assign rdata = rdata_q;
    assign drv_on = drv_on_q;
    assign ramp_level = level_q;
    assign vcm_bandgap = vcm_q;
    assign left_mute = left_mute_q;
    assign left_atten = left_atten_q;
    assign right_mute = right_mute_q;
    assign right_atten = right_atten_q;
    assign out_vol = step_bus.cur;
    assign out_mute = step_bus.mute;
    assign out_vol_pending = step_bus.pending;

    a_delay_short_load: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && drv_power_req && state_q == vol_ctrl_pkg::PWR_IDLE
            && pop_q[7:4] == 4'h1)
        |=> (state_q == vol_ctrl_pkg::PWR_DELAY && cnt_q == PON_10US_CYC)
    ) else $error("delay code 1 did not load 10 us");

    a_delay_long_load: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && drv_power_req && state_q == vol_ctrl_pkg::PWR_IDLE
            && pop_q[7:4] == 4'h4)
        |=> (cnt_q == 27'(PON_10MS))
    ) else $error("delay code 4 did not load 10 ms");

    a_ramp_step_zero: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && drv_power_req && state_q == vol_ctrl_pkg::PWR_RAMP
            && cnt_q == 27'h0000000 && pop_q[3:2] == 2'h0)
        |=> (level_q == $past(level_q) + 3'h1 && cnt_q == 27'h0000000)
    ) else $error("zero-time ramp step misbehaved");

    a_vcm_select: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && wr_stb && addr == `ADDR_POP ##1 clk_en)
        |=> (vcm_bandgap == $past(wdata[1], 2))
    ) else $error("common-mode source not taken from bit 1");

    a_left_mute_bit: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && wr_stb && addr == `ADDR_LDAC && link_q == vol_ctrl_pkg::LINK_NONE
            ##1 clk_en && !wr_stb)
        |=> (left_mute == $past(wdata[7], 2))
    ) else $error("left mute does not follow register");

    a_left_atten_code: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && wr_stb && addr == `ADDR_LDAC && link_q == vol_ctrl_pkg::LINK_NONE
            ##1 clk_en && !wr_stb)
        |=> (left_atten == $past(wdata[6:0], 2))
    ) else $error("left attenuation does not follow register");

    a_right_mute_bit: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && wr_stb && addr == `ADDR_RDAC && link_q == vol_ctrl_pkg::LINK_NONE
            ##1 clk_en && !wr_stb)
        |=> (right_mute == $past(wdata[7], 2))
    ) else $error("right mute does not follow register");

    a_right_atten_code: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && wr_stb && addr == `ADDR_RDAC && link_q == vol_ctrl_pkg::LINK_NONE
            ##1 clk_en && !wr_stb)
        |=> (right_atten == $past(wdata[6:0], 2))
    ) else $error("right attenuation does not follow register");

    a_out_mute_range: assert property (
        @(posedge clock) disable iff (!rst_b)
        out_mute == (out_vol >= 7'h76)
    ) else $error("output mute disagrees with volume code");

    a_link_left_follow: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && link_q == vol_ctrl_pkg::LINK_L_FOLLOWS_R && !wr_stb)
        |=> (left_atten == $past(rdac_q[6:0]))
    ) else $error("left volume not following right register");

    a_soft_step_now: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && soft_q == vol_ctrl_pkg::STEP_NOW)
        |=> (out_vol == $past(out_vol_target) && !out_vol_pending)
    ) else $error("immediate mode did not apply volume");

    a_soft_step_fs: assert property (
        @(posedge clock) disable iff (!rst_b)
        (clk_en && soft_q == vol_ctrl_pkg::STEP_FS && !sample_tick)
        |=> (out_vol == $past(out_vol))
    ) else $error("volume moved without a sample tick");

    a_ramp_after_delay: assert property (
        @(posedge clock) disable iff (!rst_b)
        (state_q == vol_ctrl_pkg::PWR_DELAY) |-> (level_q == 3'h0 && !drv_on)
    ) else $error("driver ramped before delay ended");

    c_driver_on: cover property (
        @(posedge clock) disable iff (!rst_b)
        $rose(drv_on)
    );

    c_link_used: cover property (
        @(posedge clock) disable iff (!rst_b)
        link_q == vol_ctrl_pkg::LINK_R_FOLLOWS_L && !right_mute
    );

    c_out_muted: cover property (
        @(posedge clock) disable iff (!rst_b)
        $rose(out_mute)
    );
endmodule

// ### logic/output_pop_consts.svh
`ifndef OUTPUT_POP_CONSTS_SVH
`define OUTPUT_POP_CONSTS_SVH

// Register byte addresses
`define ADDR_SOFT_STEP 8'h28
`define ADDR_VOL_LINK 8'h29
`define ADDR_POP 8'h2a
`define ADDR_LDAC 8'h2b
`define ADDR_RDAC 8'h2c
`define ADDR_STATUS 8'h80

// Reset values
`define RST_POP 8'h00
`define RST_DAC 8'h80
`define RST_OUT_VOL 7'h00

// Field positions
`define POP_DLY_MSB 7
`define POP_DLY_LSB 4
`define POP_RAMP_MSB 3
`define POP_RAMP_LSB 2
`define POP_VCM_BIT 1
`define DAC_MUTE_BIT 7
`define DAC_VOL_MSB 6

// First output-stage code that mutes the path
`define OUT_MUTE_MIN 7'h76
// Top driver ramp level
`define RAMP_TOP 3'h7

// Timing
`define CLK_MHZ 10
`define PON_10US_US 10
`define PON_100US_US 100
`define PON_1MS_US 1000
`define PON_10MS_US 10000
`define PON_50MS_US 50000
`define PON_100MS_US 100000
`define PON_200MS_US 200000
`define PON_400MS_US 400000
`define PON_800MS_US 800000
`define PON_4S_US 4000000
`define PON_8S_US 8000000
`define RAMP_1MS_US 1000
`define RAMP_2MS_US 2000
`define RAMP_4MS_US 4000

`endif

// ### logic/vol_ctrl_pkg.sv
package vol_ctrl_pkg;
    typedef enum logic [1:0] {PWR_IDLE, PWR_DELAY, PWR_RAMP, PWR_ON} pwr_state_t;
    typedef enum logic [1:0] {STEP_FS, STEP_2FS, STEP_NOW, STEP_RSVD} soft_mode_t;
    typedef enum logic [1:0] {LINK_NONE, LINK_L_FOLLOWS_R, LINK_R_FOLLOWS_L, LINK_NONE_B} link_mode_t;
endpackage

// ### verif/output_pop_and_dac_volume_ctrl_tb.sv
`timescale 1ns/1ns
`include "output_pop_consts.svh"
module output_pop_and_dac_volume_ctrl_tb;
    localparam int P1 = 20;
    localparam int P10 = 30;
    localparam int P50 = 40;
    localparam int P100 = 50;
    localparam int P200 = 60;
    localparam int P400 = 70;
    localparam int P800 = 80;
    localparam int P4S = 90;
    localparam int P8S = 100;
    localparam int D10US = `PON_10US_US * `CLK_MHZ;
    localparam int D100US = `PON_100US_US * `CLK_MHZ;
    localparam int D_TAB[12] = '{0, D10US, D100US, P1, P10, P50, P100, P200, P400, P800, P8S, P4S};
    localparam int R_TAB[4] = '{0, 5, 7, 9};
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic drv_power_req = 1'b0;
    logic sample_tick = 1'b0;
    logic [6:0] out_vol_target = 7'h00;
    logic [7:0] rdata;
    logic drv_on, vcm_bandgap, left_mute, right_mute, out_mute, out_vol_pending;
    logic [2:0] ramp_level;
    logic [6:0] left_atten, right_atten, out_vol;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    int run_cnt = 0;
    logic rd_d1 = 1'b0;
    logic on_prev = 1'b0;
    logic [7:0] rd_q[$];
    int on_q[$];

    output_pop_and_dac_volume_ctrl #(.PON_1MS(P1), .PON_10MS(P10), .PON_50MS(P50),
        .PON_100MS(P100), .PON_200MS(P200), .PON_400MS(P400), .PON_800MS(P800),
        .PON_4S(P4S), .PON_8S(P8S), .RAMP_1MS(5), .RAMP_2MS(7), .RAMP_4MS(9)
    ) output_pop_and_dac_volume_ctrl_i (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .drv_power_req(drv_power_req), .sample_tick(sample_tick),
        .out_vol_target(out_vol_target), .drv_on(drv_on), .ramp_level(ramp_level),
        .vcm_bandgap(vcm_bandgap), .left_mute(left_mute), .left_atten(left_atten),
        .right_mute(right_mute), .right_atten(right_atten), .out_vol(out_vol),
        .out_mute(out_mute), .out_vol_pending(out_vol_pending));

    always #50 clock = ~clock;

    task automatic give_verdict();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Cycle bookkeeping and hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        run_cnt <= drv_power_req ? run_cnt + 1 : 0;
        rd_d1 <= rd_stb && clk_en;
        if (cyc == 20000) begin
            failures = failures + 1;
            $display("BAD %0t timeout", $time);
            give_verdict();
        end
    end

    task automatic chk_rd(input logic [7:0] exp);
        samples_checked++;
        if (rdata !== exp) begin
            failures++;
            $display("BAD %0t read %h want %h", $time, rdata, exp);
        end
    endtask

    task automatic chk_on(input int exp);
        samples_checked++;
        if (run_cnt != exp) begin
            failures++;
            $display("BAD %0t power-up took %0d want %0d", $time, run_cnt, exp);
        end
    endtask

    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t outputs %h want %h", $time, got, exp);
        end
    endtask

    // Watcher: read data only in the cycle after a taken read, zero elsewhere
    initial begin
        forever begin
            @(posedge clock);
            #1;
            if (rst_b) begin
                if (rd_d1) chk_rd(rd_q.pop_front());
                else chk_rd(8'h00);
                if (drv_on === 1'b1 && on_prev !== 1'b1) chk_on(on_q.pop_front());
            end
            on_prev = drv_on;
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            sample_tick <= 1'b1;
            @(posedge clock);
            sample_tick <= 1'b0;
        end
        idle(2);
    endtask

    task automatic power_up(input logic [3:0] dc, input logic [1:0] rc);
        int k;
        on_q.push_back(D_TAB[dc] + 2 + 7 * (R_TAB[rc] + 1));
        @(posedge clock);
        drv_power_req <= 1'b1;
        for (k = 0; k < 2000 && drv_on !== 1'b1; k++) @(posedge clock);
        rd(8'h80, 8'hf9);
        @(posedge clock);
        drv_power_req <= 1'b0;
        idle(2);
        chk_out({12'h000, drv_on, ramp_level}, 16'h0000);
    endtask

    logic [7:0] v, l, r, el, er;
    logic [6:0] t;
    logic [6:0] vt[5];
    int i;
    initial begin
        void'($urandom(32'hb89f));
        idle(2);
        rst_b <= 1'b1;
        idle(1);
        chk_out({left_mute, left_atten, right_mute, right_atten}, 16'h8080);
        rd(8'h2a, 8'h00);
        rd(8'h2b, 8'h80);
        rd(8'h2c, 8'h80);
        rd(8'h28, 8'h00);
        rd(8'h29, 8'h00);
        rd(8'h30, 8'h00);
        rd(8'h80, 8'h00);
        $display("test reset_values done");

        for (i = 0; i < 6; i++) begin
            // Delay code kept below 12 and bit 0 kept zero
            v = {4'($urandom % 12), 2'($urandom), 1'($urandom), 1'b0};
            wr(8'h2a, v);
            rd(8'h2a, v);
            idle(1);
            chk_out({15'h0000, vcm_bandgap}, {15'h0000, v[1]});
        end
        wr(8'h31, 8'hff);
        rd(8'h31, 8'h00);
        wr(8'h28, 8'hff);
        rd(8'h28, 8'h03);
        @(posedge clock);
        clk_en <= 1'b0;
        addr <= 8'h2b;
        wdata <= 8'h11;
        wr_stb <= 1'b1;
        @(posedge clock);
        clk_en <= 1'b1;
        wr_stb <= 1'b0;
        rd(8'h2b, 8'h80);
        $display("test register_access done");

        for (i = 0; i < 4; i++) begin
            l = (i == 0) ? 8'h7f : 8'($urandom);
            r = (i == 0) ? 8'h80 : 8'($urandom);
            wr(8'h29, 8'(i));
            wr(8'h2b, l);
            wr(8'h2c, r);
            idle(3);
            el = (i == 1) ? r : l;
            er = (i == 2) ? l : r;
            chk_out({left_mute, left_atten, right_mute, right_atten}, {el, er});
        end
        wr(8'h29, 8'h00);
        $display("test dac_volume_link done");

        for (i = 0; i < 12; i++) begin
            wr(8'h2a, {4'(i), 2'(i % 4), 2'b00});
            power_up(4'(i), 2'(i % 4));
        end
        wr(8'h2a, 8'h34);
        @(posedge clock);
        drv_power_req <= 1'b1;
        idle(10);
        drv_power_req <= 1'b0;
        idle(2);
        chk_out({12'h000, drv_on, ramp_level}, 16'h0000);
        rd(8'h80, 8'h00);
        wr(8'h2a, 8'h00);
        power_up(4'h0, 2'h0);
        $display("test power_sequence done");

        wr(8'h28, 8'h02);
        vt = '{7'($urandom % 118), 7'h75, 7'h76, 7'h7f, 7'h00};
        for (i = 0; i < 5; i++) begin
            t = vt[i];
            @(posedge clock);
            out_vol_target <= t;
            idle(3);
            chk_out({7'h00, out_vol, out_mute, out_vol_pending}, {7'h00, t, t >= 7'h76, 1'b0});
        end
        wr(8'h28, 8'h00);
        @(posedge clock);
        out_vol_target <= 7'h06;
        idle(3);
        chk_out({7'h00, out_vol, out_mute, out_vol_pending}, {7'h00, 7'h00, 2'b01});
        tick(4);
        chk_out({7'h00, out_vol, out_mute, out_vol_pending}, {7'h00, 7'h04, 2'b01});
        tick(2);
        chk_out({7'h00, out_vol, out_mute, out_vol_pending}, {7'h00, 7'h06, 2'b00});
        wr(8'h28, 8'h01);
        @(posedge clock);
        out_vol_target <= 7'h00;
        tick(4);
        chk_out({7'h00, out_vol, out_mute, out_vol_pending}, {7'h00, 7'h04, 2'b01});
        wr(8'h28, 8'h03);
        tick(4);
        chk_out({7'h00, out_vol, out_mute, out_vol_pending}, {7'h00, 7'h04, 2'b01});
        rd(8'h80, 8'h02);
        $display("test soft_step done");
        idle(3);
        give_verdict();
    end
endmodule
